/* File: common/ata_sf_pkg.sv */
package ata_sf_pkg;
  // ****************************************
  // command and feature codes
  // ****************************************
  localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
  localparam logic [7:0] CMD_SEC_UNLOCK = 8'hF2;
  localparam logic [7:0] CMD_SEC_ERASE = 8'hF4;
  localparam logic [7:0] FEAT_BYTE_ON = 8'h01;
  localparam logic [7:0] FEAT_WCACHE_ON = 8'h02;
  localparam logic [7:0] FEAT_XFER = 8'h03;
  localparam logic [7:0] FEAT_EXTPWR_ON = 8'h09;
  localparam logic [7:0] FEAT_LOOKA_OFF = 8'h55;
  localparam logic [7:0] FEAT_KEEP_ON_SOFT = 8'h66;
  localparam logic [7:0] FEAT_NOP_A = 8'h69;
  localparam logic [7:0] FEAT_BYTE_OFF = 8'h81;
  localparam logic [7:0] FEAT_WCACHE_OFF = 8'h82;
  localparam logic [7:0] FEAT_EXTPWR_OFF = 8'h89;
  localparam logic [7:0] FEAT_NOP_B = 8'h96;
  localparam logic [7:0] FEAT_LEGACY = 8'h97;
  localparam logic [7:0] FEAT_LOOKA_ON = 8'hAA;
  localparam logic [7:0] FEAT_RESTORE_ON_SOFT = 8'hCC;
  // ****************************************
  // transfer mode types and limits
  // ****************************************
  localparam logic [4:0] XT_PIO_DEF = 5'h00;
  localparam logic [4:0] XT_PIO_FC = 5'h01;
  localparam logic [4:0] XT_MDMA = 5'h04;
  localparam logic [4:0] XT_UDMA = 5'h08;
  localparam logic [2:0] PIO_DEF_MAX = 3'h1;
  localparam logic [2:0] PIO_MAX = 3'h6;
  localparam logic [2:0] MDMA_MAX = 3'h4;
  localparam logic [2:0] UDMA_MAX = 3'h4;
  localparam logic [2:0] ADV_PIO_FIRST = 3'h5;
  localparam logic [2:0] ADV_DMA_FIRST = 3'h3;
  localparam logic [2:0] ADV_SUP_PIO = 3'h2;
  localparam logic [2:0] ADV_SUP_DMA = 3'h2;
  localparam logic [1:0] DMA_NONE = 2'h0;
  localparam logic [1:0] DMA_MW = 2'h1;
  localparam logic [1:0] DMA_ULTRA = 2'h2;
  // ****************************************
  // register map and field positions
  // ****************************************
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CONFIG = 12'h008;
  localparam logic [11:0] ADDR_SEC_CTRL = 12'h00C;
  localparam logic [11:0] ADDR_WORD128 = 12'h010;
  localparam logic [11:0] ADDR_WORD163 = 12'h014;
  localparam int ST_ERR = 0;
  localparam int ST_RDY = 6;
  localparam int ST_BSY = 7;
  localparam int ER_ABRT = 10;
  localparam int SC_FAIL = 16;
  localparam int W128_CAP = 0;
  localparam int W128_EN = 1;
  localparam int W128_LOCK = 2;
  localparam int W128_FREEZE = 3;
  localparam int W128_EXPIRE = 4;
  localparam int W128_ENH = 5;
  localparam int W128_LEVEL = 8;
  localparam int W163_PIO_SUP = 0;
  localparam int W163_DMA_SUP = 3;
  localparam int W163_PIO_SEL = 6;
  localparam int W163_DMA_SEL = 9;
  // ****************************************
  // carriers and states
  // ****************************************
  typedef struct packed {
    logic byteMode;
    logic writeCache;
    logic lookAhead;
    logic extPower;
    logic keepOnSoft;
    logic iordyOff;
    logic [2:0] pioMode;
    logic [1:0] dmaKind;
    logic [2:0] dmaMode;
  } cfg_t;
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] feature;
    logic [7:0] code;
  } cmd_t;
  typedef struct packed {
    logic enabled;
    logic locked;
    logic frozen;
    logic maxLevel;
  } sec_t;
  localparam cfg_t CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, PIO_MAX, DMA_MW,
                                 MDMA_MAX};
  localparam logic [15:0] WORD163_RESET = 16'h0492;
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_FLUSH} state_t;
endpackage

/* File: verilog/ata_set_features_identify.sv */
`timescale 1ns/1ps
module ata_set_features_identify #(
  parameter bit SEC_SUPPORTED = 1'b1,
  parameter bit ENH_ERASE = 1'b0,
  parameter int UNLOCK_TRIES = 5
) (
  input wire logic mclk, // system clock
  input wire logic resetn, // power-on reset, active low
  input wire logic hardResetn, // hard reset pin, active low
  input wire logic softReset, // software reset pin, active high
  input wire logic flushDone, // cache flush finished
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output ata_sf_pkg::cfg_t modeCfg, // active transfer and feature setup
  output logic iocs16En, // allow IOCS16 on data accesses
  output logic flushReq, // request cache flush
  output logic cmdDone // command completed pulse
);
  import ata_sf_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  // map a mode number onto the advanced 0/1/2 code
  function automatic logic [2:0] advCode(input logic [2:0] mode, input logic [2:0] first);
    if (mode == first) begin
      return 3'h1;
    end else if (mode == first + 3'h1) begin
      return 3'h2;
    end
    return 3'h0;
  endfunction

  // check a transfer mode value
  function automatic logic xferOk(input logic [7:0] v);
    case (v[7:3])
      XT_PIO_DEF: return v[2:0] <= PIO_DEF_MAX;
      XT_PIO_FC: return v[2:0] <= PIO_MAX;
      XT_MDMA: return v[2:0] <= MDMA_MAX;
      XT_UDMA: return v[2:0] <= UDMA_MAX;
      default: return 1'b0;
    endcase
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  logic [2:0] hardSync_q;
  logic [2:0] softSync_q;
  logic hardPulse;
  logic softPulse;
  state_t state_q;
  cmd_t cmd_q;
  cfg_t cfg_q;
  cfg_t cfgNew;
  sec_t sec_q;
  logic [7:0] failCnt_q;
  logic expired;
  logic bad;
  logic flushNeed;
  logic errFlag_q;
  logic abrtFlag_q;
  logic [15:0] word128;
  logic [15:0] word163;
  logic [31:0] rdMux;
  logic mapped;
  logic access;
  logic wrEn;
  logic cmdWrite;

  // ****************************************
  // reset pin synchronisers
  // ****************************************
  // three stages, edge taken from the last two
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hardSync_q <= 3'h7;
      softSync_q <= 3'h0;
    end else begin
      hardSync_q <= {hardSync_q[1:0], hardResetn};
      softSync_q <= {softSync_q[1:0], softReset};
    end
  end
  assign hardPulse = hardSync_q[2] && !hardSync_q[1];
  assign softPulse = softSync_q[1] && !softSync_q[2];

  // ****************************************
  // apb slave
  // ****************************************
  assign access = psel && penable && !pready;
  assign wrEn = psel && penable && pready && pwrite && !pslverr;
  assign cmdWrite = wrEn && (paddr == ADDR_CMD) && (state_q == S_IDLE);
  assign mapped = (paddr == ADDR_CMD) || (paddr == ADDR_STATUS) || (paddr == ADDR_CONFIG) ||
                  (paddr == ADDR_SEC_CTRL) || (paddr == ADDR_WORD128) ||
                  (paddr == ADDR_WORD163);

  // read multiplexer
  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      ADDR_CMD: rdMux = {8'h00, cmd_q};
      ADDR_STATUS: begin
        rdMux[ST_BSY] = (state_q != S_IDLE);
        rdMux[ST_RDY] = (state_q == S_IDLE);
        rdMux[ST_ERR] = errFlag_q;
        rdMux[ER_ABRT] = abrtFlag_q;
      end
      ADDR_CONFIG: rdMux = {18'h0_0000, cfg_q};
      ADDR_SEC_CTRL: rdMux = {24'h00_0000, failCnt_q};
      ADDR_WORD128: rdMux = {16'h0000, word128};
      ADDR_WORD163: rdMux = {16'h0000, word163};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // one wait state, answer registered
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      if (access) begin
        pslverr <= !mapped || (pwrite && paddr == ADDR_CMD && state_q != S_IDLE);
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************
  // feature decode
  // ****************************************
  always_comb begin
    cfgNew = cfg_q;
    bad = 1'b0;
    flushNeed = 1'b0;
    if (cmd_q.code == CMD_SET_FEATURES) begin
      case (cmd_q.feature)
        FEAT_BYTE_ON: cfgNew.byteMode = 1'b1;
        FEAT_BYTE_OFF: cfgNew.byteMode = 1'b0;
        FEAT_WCACHE_ON: cfgNew.writeCache = 1'b1;
        FEAT_WCACHE_OFF: begin
          cfgNew.writeCache = 1'b0;
          flushNeed = 1'b1;
        end
        FEAT_EXTPWR_ON: cfgNew.extPower = 1'b1;
        FEAT_EXTPWR_OFF: cfgNew.extPower = 1'b0;
        FEAT_LOOKA_OFF: cfgNew.lookAhead = 1'b0;
        FEAT_LOOKA_ON: cfgNew.lookAhead = 1'b1;
        FEAT_KEEP_ON_SOFT: cfgNew.keepOnSoft = 1'b1;
        FEAT_RESTORE_ON_SOFT: cfgNew.keepOnSoft = 1'b0;
        FEAT_NOP_A, FEAT_NOP_B, FEAT_LEGACY: bad = 1'b0;
        FEAT_XFER: begin
          if (!xferOk(cmd_q.count)) begin
            bad = 1'b1;
          end else begin
            case (cmd_q.count[7:3])
              XT_PIO_DEF: begin
                cfgNew.pioMode = 3'h0;
                cfgNew.iordyOff = cmd_q.count[0];
              end
              XT_PIO_FC: begin
                cfgNew.pioMode = cmd_q.count[2:0];
                cfgNew.iordyOff = 1'b0;
              end
              XT_MDMA: begin
                cfgNew.dmaKind = DMA_MW;
                cfgNew.dmaMode = cmd_q.count[2:0];
              end
              default: begin
                cfgNew.dmaKind = DMA_ULTRA;
                cfgNew.dmaMode = cmd_q.count[2:0];
              end
            endcase
          end
        end
        default: bad = 1'b1;
      endcase
    end else if ((cmd_q.code == CMD_SEC_UNLOCK || cmd_q.code == CMD_SEC_ERASE) && expired) begin
      bad = 1'b1;
    end
  end

  // ****************************************
  // command sequencer
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      cmd_q <= '0;
      errFlag_q <= 1'b0;
      abrtFlag_q <= 1'b0;
      flushReq <= 1'b0;
      cmdDone <= 1'b0;
    end else begin
      cmdDone <= 1'b0;
      if (hardPulse) begin
        state_q <= S_IDLE;
        flushReq <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (cmdWrite) begin
              cmd_q <= pwdata[23:0];
              errFlag_q <= 1'b0;
              abrtFlag_q <= 1'b0;
              state_q <= S_EXEC;
            end
          end
          S_EXEC: begin
            if (bad) begin
              errFlag_q <= 1'b1;
              abrtFlag_q <= 1'b1;
              cmdDone <= 1'b1;
              state_q <= S_IDLE;
            end else if (flushNeed) begin
              flushReq <= 1'b1;
              state_q <= S_FLUSH;
            end else begin
              cmdDone <= 1'b1;
              state_q <= S_IDLE;
            end
          end
          S_FLUSH: begin
            if (flushDone) begin
              flushReq <= 1'b0;
              cmdDone <= 1'b1;
              state_q <= S_IDLE;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // feature and mode settings
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= CFG_RESET;
      iocs16En <= 1'b1;
    end else begin
      if (hardPulse) begin
        cfg_q <= CFG_RESET;
      end else if (state_q == S_EXEC && !bad) begin
        cfg_q <= cfgNew;
      end else if (softPulse && !cfg_q.keepOnSoft) begin
        cfg_q.byteMode <= CFG_RESET.byteMode;
        cfg_q.writeCache <= CFG_RESET.writeCache;
        cfg_q.lookAhead <= CFG_RESET.lookAhead;
        cfg_q.extPower <= CFG_RESET.extPower;
      end
      iocs16En <= !((state_q == S_EXEC && !bad) ? cfgNew.byteMode : cfg_q.byteMode);
    end
  end
  assign modeCfg = cfg_q;

  // ****************************************
  // security state and unlock counter
  // ****************************************
  assign expired = (failCnt_q >= 8'(UNLOCK_TRIES));
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sec_q <= '0;
      failCnt_q <= 8'h00;
    end else begin
      if (wrEn && paddr == ADDR_SEC_CTRL) begin
        sec_q <= pwdata[3:0];
      end
      if (wrEn && paddr == ADDR_SEC_CTRL && pwdata[SC_FAIL] && !expired) begin
        failCnt_q <= failCnt_q + 8'h01;
      end else if (hardPulse) begin
        failCnt_q <= 8'h00;
      end
    end
  end

  // ****************************************
  // identify words
  // ****************************************
  always_comb begin
    word128 = 16'h0000;
    word128[W128_CAP] = SEC_SUPPORTED;
    word128[W128_EN] = sec_q.enabled;
    word128[W128_LOCK] = sec_q.locked;
    word128[W128_FREEZE] = sec_q.frozen;
    word128[W128_EXPIRE] = expired;
    word128[W128_ENH] = ENH_ERASE;
    word128[W128_LEVEL] = sec_q.enabled && sec_q.maxLevel;
    word163 = 16'h0000;
    word163[W163_PIO_SUP +: 3] = ADV_SUP_PIO;
    word163[W163_DMA_SUP +: 3] = ADV_SUP_DMA;
    word163[W163_PIO_SEL +: 3] = advCode(cfg_q.pioMode, ADV_PIO_FIRST);
    word163[W163_DMA_SEL +: 3] = (cfg_q.dmaKind == DMA_MW) ?
                                 advCode(cfg_q.dmaMode, ADV_DMA_FIRST) : 3'h0;
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_abort_flags: assert property (state_q == S_EXEC && bad |=> errFlag_q && abrtFlag_q && cmdDone)
    else $error("bad feature did not abort");
  a_word163_reset: assert property (cfg_q == CFG_RESET |-> word163 == WORD163_RESET)
    else $error("timing word not 0492H at defaults");
  a_pio_selected: assert property (cfg_q.pioMode == PIO_MAX |-> word163[8:6] == 3'h2)
    else $error("pio 6 not reported");
  a_dma_selected: assert property (cfg_q.dmaKind == DMA_MW && cfg_q.dmaMode == 3'h3
                                   |-> word163[11:9] == 3'h1)
    else $error("mdma 3 not reported");
  a_expire_abort: assert property (state_q == S_EXEC && expired && cmd_q.code == CMD_SEC_UNLOCK
                                   |=> errFlag_q)
    else $error("unlock not aborted after expiry");
  a_byte_mode: assert property (state_q == S_EXEC && cmd_q.code == CMD_SET_FEATURES &&
                                cmd_q.feature == FEAT_BYTE_ON |=> modeCfg.byteMode && !iocs16En)
    else $error("byte mode not taken");
  a_flush_hold: assert property (state_q == S_FLUSH && !flushDone && !hardPulse
                                 |=> state_q == S_FLUSH && flushReq && !cmdDone)
    else $error("completion before flush");
  a_pio_valid: assert property (cfg_q.pioMode <= PIO_MAX)
    else $error("no valid pio mode");
  a_level_gate: assert property (!sec_q.enabled |-> !word128[W128_LEVEL])
    else $error("level shown while disabled");
  a_mode_stable: assert property (state_q != S_EXEC && !hardPulse |=> $stable(cfg_q.pioMode))
    else $error("pio mode changed outside set features");

  c_flush: cover property (state_q == S_FLUSH ##1 cmdDone);
  c_abort: cover property (state_q == S_EXEC && bad);
  c_udma: cover property (cfg_q.dmaKind == DMA_ULTRA);
endmodule

/* File: verif/ata_host_model.sv */
`timescale 1ns/1ps
// ****************************************
// host controller and cache store model
// ****************************************
module ata_host_model (
  input wire logic mclk, // system clock
  input wire logic flushReq, // device wants a flush
  output logic flushDone, // flush finished
  output logic psel, // apb select
  output logic penable, // apb enable
  output logic pwrite, // apb direction
  output logic [11:0] paddr, // apb address
  output logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr // apb error
);
  int flushDelay = 2;
  int fCnt = 0;
  initial begin
    flushDone = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // store answers a flush after a settable delay
  always @(posedge mclk) begin
    if (flushReq === 1'b1 && !flushDone) begin
      if (fCnt >= flushDelay) begin
        flushDone <= 1'b1;
        fCnt <= 0;
      end else begin
        fCnt <= fCnt + 1;
      end
    end else begin
      flushDone <= 1'b0;
    end
  end
  // one apb transfer; request held until pready sampled high or 20 cycles pass
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err, output logic ok);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    ok = (pready === 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import ata_sf_pkg::*;
  logic mclk, resetn, hardResetn, softReset, flushDone, psel, penable, pwrite;
  logic pready, pslverr, iocs16En, flushReq, cmdDone;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st, r;
  cfg_t modeCfg, e;
  int nFail = 0;
  int testsRun = 0;
  int n;
  ata_set_features_identify #(.UNLOCK_TRIES(2)) i_dut (.mclk(mclk), .resetn(resetn),
    .hardResetn(hardResetn), .softReset(softReset), .flushDone(flushDone), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .modeCfg(modeCfg), .iocs16En(iocs16En),
    .flushReq(flushReq), .cmdDone(cmdDone));
  ata_host_model i_host (.mclk(mclk), .flushReq(flushReq), .flushDone(flushDone),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ****************************************
  // shared helpers
  // ****************************************
  task automatic print_verdict();
    if (nFail == 0 && testsRun > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic hang(input string m);
    nFail++;
    $display("[FAIL] %0t timeout %s", $time, m);
    print_verdict();
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    logic ok;
    i_host.xfer(w, a, d, q, err, ok);
    if (!ok) hang("apb");
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic err;
    bus(1'b0, a, 32'h0000_0000, q, err);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic err;
    bus(1'b1, a, d, q, err);
  endtask
  // write a command and wait for its completion, then fetch status
  task automatic sendCmd(input logic [7:0] code, input logic [7:0] feat, input logic [7:0] cnt);
    wr(ADDR_CMD, {8'h00, cnt, feat, code});
    n = 0;
    while (cmdDone !== 1'b1) begin
      @(posedge mclk);
      n++;
      if (n > 60) hang("command");
    end
    rd(ADDR_STATUS, st);
  endtask
  task automatic cfgChk(input string m);
    rd(ADDR_CONFIG, r);
    chk(32'(r[$bits(cfg_t)-1:0]), 32'(e), m);
    chk(32'(modeCfg), 32'(e), "config port");
    rd(ADDR_WORD163, r);
    chk(r, w163(e), "timing word");
  endtask
  function automatic logic [31:0] w163(input cfg_t c);
    logic [2:0] p;
    logic [2:0] d;
    p = (c.pioMode >= ADV_PIO_FIRST) ? c.pioMode - ADV_PIO_FIRST + 3'h1 : 3'h0;
    d = (c.dmaKind == DMA_MW && c.dmaMode >= ADV_DMA_FIRST) ?
        c.dmaMode - ADV_DMA_FIRST + 3'h1 : 3'h0;
    return {20'h0_0000, d, p, ADV_SUP_DMA, ADV_SUP_PIO};
  endfunction
  // ****************************************
  // scenarios
  // ****************************************
  task automatic tFeat();
    logic [7:0] fl [12];
    fl = '{FEAT_BYTE_ON, FEAT_EXTPWR_ON, FEAT_LOOKA_ON, FEAT_KEEP_ON_SOFT, FEAT_NOP_A,
           FEAT_NOP_B, FEAT_LEGACY, FEAT_BYTE_OFF, FEAT_EXTPWR_OFF, FEAT_LOOKA_OFF,
           FEAT_RESTORE_ON_SOFT, FEAT_WCACHE_ON};
    e = CFG_RESET;
    cfgChk("reset config");
    for (int i = 0; i < 12; i++) begin
      sendCmd(CMD_SET_FEATURES, fl[i], 8'h00);
      case (fl[i])
        FEAT_BYTE_ON: e.byteMode = 1'b1;
        FEAT_BYTE_OFF: e.byteMode = 1'b0;
        FEAT_EXTPWR_ON: e.extPower = 1'b1;
        FEAT_EXTPWR_OFF: e.extPower = 1'b0;
        FEAT_LOOKA_ON: e.lookAhead = 1'b1;
        FEAT_LOOKA_OFF: e.lookAhead = 1'b0;
        FEAT_KEEP_ON_SOFT: e.keepOnSoft = 1'b1;
        FEAT_RESTORE_ON_SOFT: e.keepOnSoft = 1'b0;
        FEAT_WCACHE_ON: e.writeCache = 1'b1;
        default: ;
      endcase
      cfgChk("feature config");
      chk(32'(iocs16En), 32'(!e.byteMode), "iocs16 enable");
      chk(32'(st[ST_ERR]), 32'h0, "good feature error");
    end
    i_host.flushDelay = 8;
    sendCmd(CMD_SET_FEATURES, FEAT_WCACHE_OFF, 8'h00);
    chk(32'(n > 8), 32'h1, "done before flush");
    e.writeCache = 1'b0;
    cfgChk("cache off");
  endtask
  task automatic tMode();
    logic [7:0] good [6];
    logic [7:0] bad [5];
    good = '{8'h0D, 8'h23, 8'h44, 8'h0E, 8'h24, 8'h00};
    bad = '{8'h0F, 8'h27, 8'h45, 8'h10, 8'h85};
    foreach (good[i]) begin
      sendCmd(CMD_SET_FEATURES, FEAT_XFER, good[i]);
      case (good[i][7:3])
        XT_PIO_DEF: begin
          e.pioMode = 3'h0;
          e.iordyOff = good[i][0];
        end
        XT_PIO_FC: begin
          e.pioMode = good[i][2:0];
          e.iordyOff = 1'b0;
        end
        XT_MDMA: e.dmaKind = DMA_MW;
        XT_UDMA: e.dmaKind = DMA_ULTRA;
        default: ;
      endcase
      if (good[i][7:3] != XT_PIO_FC && good[i][7:3] != XT_PIO_DEF) e.dmaMode = good[i][2:0];
      chk(32'(st[ST_ERR]), 32'h0, "mode accepted");
      cfgChk("mode select");
    end
    foreach (bad[i]) begin
      rd(ADDR_CONFIG, r);
      sendCmd(CMD_SET_FEATURES, FEAT_XFER, bad[i]);
      chk({st[ER_ABRT], st[ST_ERR]}, 2'b11, "bad mode abort");
      rd(ADDR_CONFIG, st);
      chk(st, r, "bad mode kept");
    end
    sendCmd(CMD_SET_FEATURES, 8'h33, 8'h00);
    chk({st[ER_ABRT], st[ST_ERR]}, 2'b11, "bad feature abort");
    sendCmd(CMD_SET_FEATURES, FEAT_XFER, 8'h01);
    rd(ADDR_CONFIG, r);
    chk({st[ST_ERR], r[$bits(cfg_t)-6]}, 2'b01, "iordy off");
  endtask
  task automatic tSec();
    for (int v = 0; v < 16; v++) begin
      wr(ADDR_SEC_CTRL, 32'(v));
      rd(ADDR_WORD128, r);
      chk(r, {23'h0, v[3] & v[0], 4'h0, v[1], v[2], v[3], 1'b1}, "sec word");
    end
    wr(ADDR_SEC_CTRL, 32'h0000_0000);
    sendCmd(CMD_SEC_UNLOCK, 8'h00, 8'h00);
    chk(32'(st[ER_ABRT]), 32'h0, "unlock before expiry");
    wr(ADDR_SEC_CTRL, 32'h0001_0000);
    wr(ADDR_SEC_CTRL, 32'h0001_0000);
    rd(ADDR_WORD128, r);
    chk(r, 32'h0000_0011, "expired");
    sendCmd(CMD_SEC_UNLOCK, 8'h00, 8'h00);
    chk(32'(st[ER_ABRT]), 32'h1, "unlock aborted");
    sendCmd(CMD_SEC_ERASE, 8'h00, 8'h00);
    chk(32'(st[ER_ABRT]), 32'h1, "erase aborted");
    @(posedge mclk);
    hardResetn <= 1'b0;
    repeat (6) @(posedge mclk);
    hardResetn <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(ADDR_WORD128, r);
    chk(r, 32'h0000_0001, "expiry cleared");
    e = CFG_RESET;
    cfgChk("hard reset config");
    sendCmd(CMD_SEC_UNLOCK, 8'h00, 8'h00);
    chk(32'(st[ER_ABRT]), 32'h0, "unlock after hard reset");
  endtask
  task automatic softPulse();
    @(posedge mclk);
    softReset <= 1'b1;
    repeat (4) @(posedge mclk);
    softReset <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  task automatic tSoft();
    sendCmd(CMD_SET_FEATURES, FEAT_WCACHE_ON, 8'h00);
    sendCmd(CMD_SET_FEATURES, FEAT_LOOKA_ON, 8'h00);
    softPulse();
    cfgChk("soft restores");
    sendCmd(CMD_SET_FEATURES, FEAT_KEEP_ON_SOFT, 8'h00);
    sendCmd(CMD_SET_FEATURES, FEAT_WCACHE_ON, 8'h00);
    softPulse();
    e.keepOnSoft = 1'b1;
    e.writeCache = 1'b1;
    cfgChk("soft keeps");
    bus(1'b0, 12'h018, 32'h0000_0000, r, st[0]);
    chk(r, 32'h0000_0000, "unmapped read");
    chk(32'(st[0]), 32'h0000_0001, "unmapped error");
  endtask
  initial begin
    resetn = 1'b0;
    hardResetn = 1'b1;
    softReset = 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    tFeat();
    tMode();
    tSec();
    tSoft();
    print_verdict();
  end
endmodule
